// ===== rtl/tpo_pkg.sv
// Package of constants for the timing pattern output register block
package tpo_pkg;
    // Register offsets (printed offsets are not all multiples of four: indices)
    localparam logic [15:0] IDX_HIGH_PAIR = 16'hFFA4;
    localparam logic [15:0] IDX_LOW_PAIR = 16'hFFA5;
    localparam logic [15:0] IDX_GRP2_ALIAS = 16'hFFA6;
    localparam logic [15:0] IDX_GRP0_ALIAS = 16'hFFA7;
    localparam logic [15:0] IDX_TRIG_SEL = 16'hFFA1;
    localparam logic [15:0] IDX_HIGH_EN = 16'hFFA2;
    localparam logic [15:0] IDX_LOW_EN = 16'hFFA3;
    localparam logic [15:0] IDX_LOW_DIR = 16'hFFD1;
    localparam logic [15:0] IDX_LOW_DATA = 16'hFFD3;
    localparam logic [15:0] IDX_HIGH_DIR = 16'hFFD4;
    localparam logic [15:0] IDX_HIGH_DATA = 16'hFFD6;
    // Reset values
    localparam logic [7:0] RST_NEXT_DATA = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_PORT_DATA = 8'h00;
    localparam logic [7:0] RESERVED_ONES = 8'hFF;
    // Trigger select field positions, two bits per group
    localparam int SEL_GRP0_LSB = 0;
    localparam int SEL_GRP1_LSB = 2;
    localparam int SEL_GRP2_LSB = 4;
    localparam int SEL_GRP3_LSB = 6;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_CHANNELS = 4;
    // Timer channel codes
    typedef enum logic [1:0] {
        TPO_CH0 = 2'b00,
        TPO_CH1 = 2'b01,
        TPO_CH2 = 2'b10,
        TPO_CH3 = 2'b11
    } tpo_chan_t;
endpackage

// ===== rtl/tpo_group_xfer.sv
// One 4-bit output group: trigger selection and masked next-data transfer
module tpo_group_xfer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Timer triggers and group trigger select
    input wire logic [3:0] cmp_match,
    input wire logic [1:0] trig_sel,
    // Data sources
    input wire logic [3:0] next_data,
    input wire logic [3:0] bit_enables,
    input wire logic [3:0] sw_wdata,
    input wire logic sw_we,
    // Port data nibble
    output logic [3:0] port_data
);
    logic [3:0] port_data_reg;
    logic [3:0] port_data_next;
    wire trig_hit;
    wire [3:0] sw_data;

    // Channel decode of the group trigger
    assign trig_hit = cmp_match[trig_sel]; // RQ15 RQ16 RQ17 RQ18 RQ19 RQ21
    // Software writes reach only disabled bits
    assign sw_data = sw_we ? ((sw_wdata & ~bit_enables) | (port_data_reg & bit_enables)) : port_data_reg; // RQ3
    // Trigger moves enabled next-data bits in; disabled bits keep sw_data (held, or a software write in the same cycle)
    assign port_data_next = trig_hit ? ((next_data & bit_enables) | (sw_data & ~bit_enables)) : sw_data; // RQ11 RQ12

    // Port data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_reg <= tpo_pkg::RST_PORT_DATA[3:0];
        end else begin
            port_data_reg <= port_data_next;
        end
    end
    assign port_data = port_data_reg;

    AST_XFER_ENABLED: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
        trig_hit |=> ((port_data & $past(bit_enables)) == ($past(next_data) & $past(bit_enables))))
        else $error("enabled bits not loaded on trigger");
    AST_RO_ENABLED: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        (!trig_hit && sw_we) |=> ((port_data & $past(bit_enables)) == ($past(port_data) & $past(bit_enables))))
        else $error("software wrote an enabled bit");
    AST_HOLD_DISABLED: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
        (!sw_we) |=> ((port_data & ~$past(bit_enables)) == ($past(port_data) & ~$past(bit_enables))))
        else $error("disabled bit changed");
endmodule

// ===== rtl/tpo_regs.sv
// Timing pattern output register file, APB slave and group transfer logic
// Functional notes
// RQ1: Software sets direction bits for pattern pins
// RQ2: Low port data holds groups zero, one
// RQ3: Enabled port data bits ignore software writes
// RQ4: Selected trigger copies low next data
// RQ5: Selected trigger copies high next data
// RQ6: Next data resets to zero
// RQ7: Shared low trigger: one register, alias ones
// RQ8: Split low trigger: nibbles at two addresses
// RQ9: Shared high trigger: one register, alias ones
// RQ10: Split high trigger: nibbles at two addresses
// RQ11: Enabled low bits transfer, disabled hold
// RQ12: Enabled high bits transfer, disabled hold
// RQ13: Enable registers read/write, reset to zero
// RQ14: Trigger select resets to all ones
// RQ15: Bits seven, six pick group three channel
// RQ16: Bits five, four pick group two channel
// RQ17: Bits three, two pick group one channel
// RQ18: Bits one, zero pick group zero channel
// RQ19: Group zero codes one to three
// RQ20: Pin drives only when direction and enable
// RQ21: Trigger pulse loads all selecting groups together
//
// Our own choice: the APB slave port.
module tpo_regs (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer compare-match pulses, one per channel
    input wire logic [3:0] cmp_match,
    // Pattern pins
    output logic [15:0] pattern_pins,
    output logic [15:0] pattern_pins_oe,
    output logic [15:0] pattern_active
);
    // Default clock and reset for every property
    default clocking dflt_clk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] next_data_low_pair_reg;
    logic [7:0] next_data_high_pair_reg;
    logic [7:0] low_transfer_enable_reg;
    logic [7:0] high_transfer_enable_reg;
    logic [7:0] group_trigger_select_reg;
    logic [7:0] low_port_direction_reg;
    logic [7:0] high_port_direction_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [15:0] pins_reg;
    logic [15:0] oe_reg;
    wire [15:0] port_data;
    logic [31:0] prdata_next;
    logic [15:0] pin_drive;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
        hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    wire setup = psel && !penable;
    wire wr = psel && penable && pready_reg && pwrite && pstrb[0];
    wire [1:0] sel_g0 = group_trigger_select_reg[tpo_pkg::SEL_GRP0_LSB +: 2];
    wire [1:0] sel_g1 = group_trigger_select_reg[tpo_pkg::SEL_GRP1_LSB +: 2];
    wire [1:0] sel_g2 = group_trigger_select_reg[tpo_pkg::SEL_GRP2_LSB +: 2];
    wire [1:0] sel_g3 = group_trigger_select_reg[tpo_pkg::SEL_GRP3_LSB +: 2];
    wire low_shared = (sel_g0 == sel_g1); // RQ7 RQ8
    wire high_shared = (sel_g2 == sel_g3); // RQ9 RQ10
    wire a_hpair = hit(paddr, tpo_pkg::IDX_HIGH_PAIR);
    wire a_lpair = hit(paddr, tpo_pkg::IDX_LOW_PAIR);
    wire a_g2 = hit(paddr, tpo_pkg::IDX_GRP2_ALIAS);
    wire a_g0 = hit(paddr, tpo_pkg::IDX_GRP0_ALIAS);
    wire a_tsel = hit(paddr, tpo_pkg::IDX_TRIG_SEL);
    wire a_hen = hit(paddr, tpo_pkg::IDX_HIGH_EN);
    wire a_len = hit(paddr, tpo_pkg::IDX_LOW_EN);
    wire a_ldir = hit(paddr, tpo_pkg::IDX_LOW_DIR);
    wire a_ldat = hit(paddr, tpo_pkg::IDX_LOW_DATA);
    wire a_hdir = hit(paddr, tpo_pkg::IDX_HIGH_DIR);
    wire a_hdat = hit(paddr, tpo_pkg::IDX_HIGH_DATA);
    wire mapped = a_hpair | a_lpair | a_g2 | a_g0 | a_tsel | a_hen | a_len | a_ldir | a_ldat | a_hdir | a_hdat;
    wire [7:0] wb = pwdata[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Next-data write steering per nibble (upper at pair, lower at pair or alias)
    wire wr_g1 = wr && a_lpair; // RQ7 RQ8
    wire wr_g0 = wr && (low_shared ? a_lpair : a_g0); // RQ7 RQ8
    wire wr_g3 = wr && a_hpair; // RQ9 RQ10
    wire wr_g2 = wr && (high_shared ? a_hpair : a_g2); // RQ9 RQ10
    wire [7:0] ndl_next = {wr_g1 ? wb[7:4] : next_data_low_pair_reg[7:4],
                           wr_g0 ? wb[3:0] : next_data_low_pair_reg[3:0]};
    wire [7:0] ndh_next = {wr_g3 ? wb[7:4] : next_data_high_pair_reg[7:4],
                           wr_g2 ? wb[3:0] : next_data_high_pair_reg[3:0]};

    // Next-data, enable, select and direction registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_data_low_pair_reg <= tpo_pkg::RST_NEXT_DATA; // RQ6
            next_data_high_pair_reg <= tpo_pkg::RST_NEXT_DATA; // RQ6
            low_transfer_enable_reg <= tpo_pkg::RST_ENABLE; // RQ13
            high_transfer_enable_reg <= tpo_pkg::RST_ENABLE; // RQ13
            group_trigger_select_reg <= tpo_pkg::RST_TRIG_SEL; // RQ14
            low_port_direction_reg <= tpo_pkg::RST_DIR;
            high_port_direction_reg <= tpo_pkg::RST_DIR;
        end else begin
            next_data_low_pair_reg <= ndl_next;
            next_data_high_pair_reg <= ndh_next;
            if (wr && a_len) begin
                low_transfer_enable_reg <= wb; // RQ13
            end
            if (wr && a_hen) begin
                high_transfer_enable_reg <= wb; // RQ13
            end
            if (wr && a_tsel) begin
                group_trigger_select_reg <= wb;
            end
            if (wr && a_ldir) begin
                low_port_direction_reg <= wb; // RQ1
            end
            if (wr && a_hdir) begin
                high_port_direction_reg <= wb; // RQ1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Four group transfer units, one trigger pulse per channel
    wire [15:0] nd_all = {next_data_high_pair_reg, next_data_low_pair_reg};
    wire [15:0] en_all = {high_transfer_enable_reg, low_transfer_enable_reg};
    wire [15:0] wd_all = {wb, wb};
    wire [3:0] dat_we = {wr && a_hdat, wr && a_hdat, wr && a_ldat, wr && a_ldat};

    genvar g;
    generate
        for (g = 0; g < tpo_pkg::NUM_GROUPS; g++) begin : gen_grp
            tpo_group_xfer u_grp (
                .pclk(pclk),
                .presetn(presetn),
                .cmp_match(cmp_match),
                .trig_sel(group_trigger_select_reg[2*g +: 2]),
                .next_data(nd_all[4*g +: 4]),
                .bit_enables(en_all[4*g +: 4]),
                .sw_wdata(wd_all[4*g +: 4]),
                .sw_we(dat_we[g]),
                .port_data(port_data[4*g +: 4])
            ); // RQ2 RQ4 RQ5 RQ21
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; reserved alias nibbles read as ones
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (a_lpair) begin
            prdata_next[7:0] = low_shared ? next_data_low_pair_reg :
                               {next_data_low_pair_reg[7:4], tpo_pkg::RESERVED_ONES[3:0]}; // RQ7 RQ8
        end else if (a_g0) begin
            prdata_next[7:0] = low_shared ? tpo_pkg::RESERVED_ONES :
                               {tpo_pkg::RESERVED_ONES[7:4], next_data_low_pair_reg[3:0]}; // RQ7 RQ8
        end else if (a_hpair) begin
            prdata_next[7:0] = high_shared ? next_data_high_pair_reg :
                               {next_data_high_pair_reg[7:4], tpo_pkg::RESERVED_ONES[3:0]}; // RQ9 RQ10
        end else if (a_g2) begin
            prdata_next[7:0] = high_shared ? tpo_pkg::RESERVED_ONES :
                               {tpo_pkg::RESERVED_ONES[7:4], next_data_high_pair_reg[3:0]}; // RQ9 RQ10
        end else if (a_tsel) begin
            prdata_next[7:0] = group_trigger_select_reg;
        end else if (a_len) begin
            prdata_next[7:0] = low_transfer_enable_reg;
        end else if (a_hen) begin
            prdata_next[7:0] = high_transfer_enable_reg;
        end else if (a_ldat) begin
            prdata_next[7:0] = port_data[7:0];
        end else if (a_hdat) begin
            prdata_next[7:0] = port_data[15:8];
        end
    end

    // APB answer: no wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            prdata_reg <= (setup && !pwrite) ? prdata_next : prdata_reg;
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive: direction and enable both set
    assign pin_drive = {high_port_direction_reg, low_port_direction_reg} & en_all; // RQ20
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_reg <= 16'h0000;
            oe_reg <= 16'h0000;
        end else begin
            pins_reg <= port_data;
            oe_reg <= pin_drive; // RQ20
        end
    end
    assign pattern_pins = pins_reg;
    assign pattern_pins_oe = oe_reg; // RQ20
    assign pattern_active = oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions, under the default clock and reset above

    // Pin enable is direction and enable, one cycle late
    AST_OE_RULE: assert property ( // RQ20
        ##1
        (pattern_active == $past(pin_drive)))
        else $error("pin enable not direction and enable");

    // Drive enable output follows the same product
    AST_OE_PORT: assert property ( // RQ20
        ##1
        (pattern_pins_oe == $past(pin_drive)))
        else $error("drive enable output wrong");

    // Pins show the port data one cycle late
    AST_PINS_COPY: assert property ( // RQ2
        ##1
        (pattern_pins == $past(port_data)))
        else $error("pins do not follow port data");

    // Shared low trigger: group 0 alias ignores writes
    AST_ALIAS_RO: assert property ( // RQ7
        wr && a_g0 && low_shared
        |=> $stable(next_data_low_pair_reg))
        else $error("reserved alias write changed next data");

    // Shared low trigger: pair takes the whole byte
    AST_SHARED_G1: assert property ( // RQ7
        wr && a_lpair && low_shared
        |=> (next_data_low_pair_reg == $past(wb)))
        else $error("shared low write lost");

    // Shared low trigger: group 0 alias reads ones
    AST_READ_G0_ONES: assert property ( // RQ7
        setup && !pwrite && a_g0 && low_shared
        |=> (prdata[7:0] == tpo_pkg::RESERVED_ONES))
        else $error("shared low alias not read as ones");

    // Split low trigger: group 0 nibble written at alias
    AST_SPLIT_G0: assert property ( // RQ8
        wr && a_g0 && !low_shared
        |=> (next_data_low_pair_reg[3:0] == $past(wb[3:0])))
        else $error("group 0 alias write lost");

    // Split low trigger: pair writes only group 1
    AST_SPLIT_G1: assert property ( // RQ8
        wr && a_lpair && !low_shared
        |=> (next_data_low_pair_reg == {$past(wb[7:4]), $past(next_data_low_pair_reg[3:0])}))
        else $error("split low pair write wrong");

    // Split low trigger: reserved pair nibble reads ones
    AST_READ_SPLIT_LOW: assert property ( // RQ8
        setup && !pwrite && a_lpair && !low_shared
        |=> (prdata[3:0] == tpo_pkg::RESERVED_ONES[3:0]))
        else $error("split low reserved nibble not ones");

    // Shared high trigger: group 2 alias ignores writes
    AST_ALIAS_G2_RO: assert property ( // RQ9
        wr && a_g2 && high_shared
        |=> $stable(next_data_high_pair_reg))
        else $error("reserved high alias write changed next data");

    // Shared high trigger: pair takes the whole byte
    AST_SHARED_G3: assert property ( // RQ9
        wr && a_hpair && high_shared
        |=> (next_data_high_pair_reg == $past(wb)))
        else $error("shared high write lost");

    // Split high trigger: pair leaves group 2 alone
    AST_SPLIT_G2: assert property ( // RQ10
        wr && a_hpair && !high_shared
        |=> (next_data_high_pair_reg[3:0] == $past(next_data_high_pair_reg[3:0])))
        else $error("group 2 nibble written at pair");

    // Split high trigger: group 2 nibble written at alias
    AST_SPLIT_G2W: assert property ( // RQ10
        wr && a_g2 && !high_shared
        |=> (next_data_high_pair_reg[3:0] == $past(wb[3:0])))
        else $error("group 2 alias write lost");

    // Group 0 loads enabled bits on its trigger
    AST_LOW_XFER: assert property ( // RQ4
        cmp_match[sel_g0]
        |=> ((port_data[3:0] & $past(en_all[3:0])) == ($past(nd_all[3:0]) & $past(en_all[3:0]))))
        else $error("group 0 transfer missed");

    // Group 1 loads enabled bits on its trigger
    AST_G1_XFER: assert property ( // RQ4
        cmp_match[sel_g1]
        |=> ((port_data[7:4] & $past(en_all[7:4])) == ($past(nd_all[7:4]) & $past(en_all[7:4]))))
        else $error("group 1 transfer missed");

    // Group 2 loads enabled bits on its trigger
    AST_G2_XFER: assert property ( // RQ5
        cmp_match[sel_g2]
        |=> ((port_data[11:8] & $past(en_all[11:8])) == ($past(nd_all[11:8]) & $past(en_all[11:8]))))
        else $error("group 2 transfer missed");

    // Group 3 loads enabled bits on its trigger
    AST_HIGH_XFER: assert property ( // RQ5
        cmp_match[sel_g3]
        |=> ((port_data[15:12] & $past(en_all[15:12])) == ($past(nd_all[15:12]) & $past(en_all[15:12]))))
        else $error("group 3 transfer missed");

    // Low enable register takes the written byte
    AST_EN_WRITE: assert property ( // RQ13
        wr && a_len
        |=> (low_transfer_enable_reg == $past(wb)))
        else $error("low enable write lost");

    // High enable register takes the written byte
    AST_HEN_WRITE: assert property ( // RQ13
        wr && a_hen
        |=> (high_transfer_enable_reg == $past(wb)))
        else $error("high enable write lost");

    // Trigger select takes the written byte
    AST_SEL_WRITE: assert property ( // RQ15
        wr && a_tsel
        |=> (group_trigger_select_reg == $past(wb)))
        else $error("trigger select write lost");

    // One access cycle answers every setup
    AST_APB_READY: assert property ( // RQ13
        setup
        |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");

    // Main scenarios reached
    COV_SPLIT_LOW: cover property (wr && a_g0 && !low_shared);
    COV_TRIG: cover property (cmp_match[sel_g2] && |en_all[11:8]);
    COV_SLVERR: cover property (pslverr && pready);
    COV_SHARED_XFER: cover property (cmp_match[sel_g0] && low_shared && |en_all[7:0]);
    COV_RO_WRITE: cover property (wr && a_ldat && |low_transfer_enable_reg);
endmodule

// ===== testbench/tpo_timer_model.sv
// Behavioural timer unit giving one-clock compare-match pulses
module tpo_timer_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pulse request from the bench
    input wire logic go,
    input wire logic [1:0] ch,
    input wire logic [2:0] dly,
    // Compare-match pulses, one per channel
    output logic [3:0] cmp_match
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_reg;
    logic [1:0] ch_reg;
    logic busy_reg;
    ////////////////////////////////////////////////////////////////
    // Count the delay down, then pulse once on the chosen channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 3'h0;
            ch_reg <= 2'h0;
            busy_reg <= 1'b0;
            cmp_match <= 4'h0;
        end else if (go) begin
            cnt_reg <= dly;
            ch_reg <= ch;
            busy_reg <= 1'b1;
            cmp_match <= 4'h0;
        end else if (busy_reg && cnt_reg == 3'h0) begin
            busy_reg <= 1'b0;
            cmp_match <= 4'h1 << ch_reg;
        end else begin
            cnt_reg <= cnt_reg - 3'h1;
            cmp_match <= 4'h0;
        end
    end
endmodule

// ===== testbench/timing_pattern_output_regs_tb.sv
// Self-checking bench for the pattern output register block
module timing_pattern_output_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, lfsr;
    logic [3:0] cmp_match;
    logic [1:0] ch;
    logic [2:0] dly;
    logic [15:0] pins, oe, act, pd, nd, en;
    logic [7:0] sel;
    logic [8:0] exp_q[$];
    int n_errors, cmp_count;
    ////////////////////////////////////////////////////////////////
    // Design, timer partner and clock
    tpo_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_match(cmp_match), .pattern_pins(pins), .pattern_pins_oe(oe), .pattern_active(act));
    tpo_timer_model tmr (.pclk(pclk), .presetn(presetn), .go(go), .ch(ch), .dly(dly), .cmp_match(cmp_match));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    // Compare, verdict and random source
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    ////////////////////////////////////////////////////////////////
    // APB master; the note holds {pslverr, read byte}
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d, input logic [8:0] e);
        int n;
        exp_q.push_back(wr ? {e[8], 8'h00} : e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Watcher takes the oldest note at each answer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            check({7'h0, pslverr, pwrite ? 8'h00 : prdata[7:0]}, {7'h0, exp_q.pop_front()});
        end
    end
    ////////////////////////////////////////////////////////////////
    // Timer pulse on one channel, then expected port data update
    task automatic fire(input logic [1:0] c);
        int n;
        logic [15:0] m;
        @(posedge pclk);
        go <= 1'b1;
        ch <= c;
        lfsr = nxt(lfsr);
        dly <= lfsr[2:0];
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cmp_match === 4'h0 && n < 20);
        if (n >= 20) begin
            n_errors++;
            print_verdict();
        end
        for (int g = 0; g < 4; g++) begin
            if (sel[2*g +: 2] == c) begin
                m = (16'hF << 4*g) & en;
                pd = (pd & ~m) | (nd & m);
            end
        end
        repeat (2) @(posedge pclk);
        check(pins, pd);
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        go = 1'b0;
        ch = 2'h0;
        dly = 3'h0;
        n_errors = 0;
        cmp_count = 0;
        lfsr = 32'h803D;
        pd = 16'h0;
        nd = 16'h0;
        en = 16'h3FF3;
        sel = 8'hFF;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check(pins, 16'h0000);
        apb(1'b0, tpo_pkg::IDX_TRIG_SEL, 8'h00, 9'h0FF);
        apb(1'b0, tpo_pkg::IDX_HIGH_EN, 8'h00, 9'h000);
        apb(1'b0, tpo_pkg::IDX_LOW_EN, 8'h00, 9'h000);
        apb(1'b0, tpo_pkg::IDX_LOW_PAIR, 8'h00, 9'h000);
        apb(1'b0, tpo_pkg::IDX_HIGH_PAIR, 8'h00, 9'h000);
        apb(1'b1, 16'hFFA0, 8'h12, 9'h100);
        apb(1'b1, tpo_pkg::IDX_LOW_DIR, 8'hFF, 9'h000);
        apb(1'b1, tpo_pkg::IDX_HIGH_DIR, 8'hFF, 9'h000);
        apb(1'b1, tpo_pkg::IDX_LOW_DATA, 8'hA5, 9'h000);
        apb(1'b1, tpo_pkg::IDX_HIGH_DATA, 8'h3C, 9'h000);
        pd = 16'h3CA5;
        repeat (2) @(posedge pclk);
        check(pins, pd);
        apb(1'b1, tpo_pkg::IDX_HIGH_EN, en[15:8], 9'h000);
        apb(1'b1, tpo_pkg::IDX_LOW_EN, en[7:0], 9'h000);
        apb(1'b0, tpo_pkg::IDX_LOW_EN, 8'h00, {1'b0, en[7:0]});
        check(oe, en);
        check(act, en);
        apb(1'b1, tpo_pkg::IDX_HIGH_DIR, 8'h0F, 9'h000);
        repeat (2) @(posedge pclk);
        check(oe, en & 16'h0FFF);
        check(act, en & 16'h0FFF);
        apb(1'b1, tpo_pkg::IDX_HIGH_DIR, 8'hFF, 9'h000);
        apb(1'b1, tpo_pkg::IDX_LOW_DATA, 8'h00, 9'h000);
        pd[7:0] = pd[7:0] & en[7:0];
        apb(1'b0, tpo_pkg::IDX_LOW_DATA, 8'h00, {1'b0, pd[7:0]});
        // Every select code on every group, split nibble addressing
        for (int r = 0; r < 4; r++) begin
            for (int g = 0; g < 4; g++) begin
                sel[2*g +: 2] = 2'(g + r);
            end
            apb(1'b1, tpo_pkg::IDX_TRIG_SEL, sel, 9'h000);
            apb(1'b0, tpo_pkg::IDX_TRIG_SEL, 8'h00, {1'b0, sel});
            lfsr = nxt(lfsr);
            apb(1'b1, tpo_pkg::IDX_LOW_PAIR, lfsr[7:0], 9'h000);
            apb(1'b1, tpo_pkg::IDX_GRP0_ALIAS, lfsr[15:8], 9'h000);
            apb(1'b1, tpo_pkg::IDX_HIGH_PAIR, lfsr[23:16], 9'h000);
            apb(1'b1, tpo_pkg::IDX_GRP2_ALIAS, lfsr[31:24], 9'h000);
            apb(1'b0, tpo_pkg::IDX_LOW_PAIR, 8'h00, {1'b0, lfsr[7:4], 4'hF});
            apb(1'b0, tpo_pkg::IDX_GRP0_ALIAS, 8'h00, {5'h0F, lfsr[11:8]});
            apb(1'b0, tpo_pkg::IDX_HIGH_PAIR, 8'h00, {1'b0, lfsr[23:20], 4'hF});
            apb(1'b0, tpo_pkg::IDX_GRP2_ALIAS, 8'h00, {5'h0F, lfsr[27:24]});
            nd = {lfsr[23:20], lfsr[27:24], lfsr[7:4], lfsr[11:8]};
            for (int c = 0; c < 4; c++) begin
                fire(2'(c));
            end
        end
        // Shared trigger: whole-byte pairs, aliases read ones
        sel = 8'h00;
        apb(1'b1, tpo_pkg::IDX_TRIG_SEL, sel, 9'h000);
        apb(1'b1, tpo_pkg::IDX_GRP2_ALIAS, 8'h00, 9'h000);
        apb(1'b1, tpo_pkg::IDX_GRP0_ALIAS, 8'h00, 9'h000);
        apb(1'b0, tpo_pkg::IDX_GRP0_ALIAS, 8'h00, 9'h0FF);
        apb(1'b0, tpo_pkg::IDX_GRP2_ALIAS, 8'h00, 9'h0FF);
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            apb(1'b1, tpo_pkg::IDX_LOW_PAIR, lfsr[7:0], 9'h000);
            apb(1'b1, tpo_pkg::IDX_HIGH_PAIR, lfsr[15:8], 9'h000);
            apb(1'b0, tpo_pkg::IDX_HIGH_PAIR, 8'h00, {1'b0, lfsr[15:8]});
            nd = lfsr[15:0];
            fire(2'h3);
            fire(2'h0);
        end
        print_verdict();
    end
endmodule
